/* hdl/nsp_page_buffer_ctrl.sv */
// Overview of operation
// (RL1) flash write and erase always cover a whole page, never part of one
// (RL2) flash splits into boot, code and data sections in 256-byte blocks
// (RL3) boot below boot end, code up to code end, data above
// (RL4) code end of zero makes code reach the flash top, no data section
// (RL5) both ends zero make the whole flash a boot section
// (RL6) software sets code end to zero or not below boot end
// (RL7) boot code may alter code and data; code may alter data
// (RL8) code running from data section may alter no flash or eeprom
// (RL9) code and boot locks block updates until the next reset
// (RL10) cpu writes never change the boot section
// (RL11) boot lock refuses reads and fetches of the boot section
// (RL12) eeprom erases and writes only the bytes marked in the buffer
// (RL13) user row is an eeprom page; debug port may write it locked
// (RL14) array reads during a write or erase stall until it ends
// (RL15) flash, eeprom and user row share one page buffer
// (RL16) stores load the buffer, low address bits choose the byte
// (RL17) each buffer store keeps new data ANDed with old content
// (RL18) buffer goes all ones on reset, op end, clear, sleep, wake
// (RL19) software erases a flash page before programming it
// (RL20) filling the buffer and committing it are separate commands
// (RL21) eeprom programming does not halt the cpu
// (RL22) software checks busy, writes key, then command within four
// (RL23) erase acts only once a byte was written into the buffer
// (RL24) eeprom ready flag raises a request while enabled
// (RL25) protection or lock violations are discarded, memory unchanged
//
// Added by the designer: the register addresses and the APB register port.
module nsp_page_buffer_ctrl
    import nsp_pkg::*;
#(
    parameter int PAGE_BYTES = 64,
    parameter int FLASH_BYTES = 8192
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic memReq,
    input wire logic memWrite,
    input wire logic [ADDR_W-1:0] memAddr,
    input wire logic [7:0] memWdata,
    output logic [7:0] memRdata,
    output logic memReady,
    output logic memError,
    input wire logic [ADDR_W-1:0] execAddr,
    output logic fetchBlocked,
    output logic cpuHalt,
    input wire logic [7:0] bootSectionEnd,
    input wire logic [7:0] appCodeSectionEnd,
    input wire logic sleepEnter,
    input wire logic wakeUp,
    input wire logic debugAccess,
    output logic [ADDR_W-1:0] arrRdAddr,
    input wire logic [7:0] arrRdData,
    output logic opValid,
    output logic [CMD_W-1:0] opKind,
    output logic [1:0] opRegion,
    output logic [ADDR_W-1:0] opPageAddr,
    output logic [PAGE_BYTES*8-1:0] opData,
    output logic [PAGE_BYTES-1:0] opMask,
    input wire logic opDone,
    output logic flashBusyFlag,
    output logic eepromBusyFlag,
    output logic eepromReadyEvent
);
    localparam int PG_W = $clog2(PAGE_BYTES);

    // refuse shapes the address logic cannot serve
    if (PAGE_BYTES < 2 || PAGE_BYTES > 256 ||
        (1 << PG_W) != PAGE_BYTES) begin : g_bad_page
        $error("page size must be a power of two from 2 to 256");
    end
    if (FLASH_BYTES < 256 ||
        FLASH_BYTES > (1 << ADDR_W) - int'(FLASH_BASE)) begin : g_bad_fl
        $error("flash size does not fit the address map");
    end

    localparam logic [ADDR_W-1:0] FLASH_TOP =
        ADDR_W'(int'(FLASH_BASE) + FLASH_BYTES);
    localparam logic [ADDR_W-1:0] PAGE_MASK = ~ADDR_W'(PAGE_BYTES - 1);

    // which array an address falls in
    function automatic nsp_region_e regionOf(input logic [ADDR_W-1:0] a);
        if (a >= FLASH_BASE && a < FLASH_TOP) begin
            return RGN_FLASH;
        end else if (a >= EEPROM_BASE && a < EEPROM_BASE + EEPROM_BYTES) begin
            return RGN_EEPROM;
        end else if (a >= USERROW_BASE &&
                     a < USERROW_BASE + USERROW_BYTES) begin
            return RGN_USERROW;
        end
        return RGN_NONE;
    endfunction

    // which flash section a flash address falls in
    function automatic nsp_section_e sectionOf(
        input logic [ADDR_W-1:0] a,
        input logic [7:0] boot_section_end,
        input logic [7:0] codeEnd
    );
        logic [ADDR_W-1:0] off;
        logic [ADDR_W-1:0] bootLim;
        logic [ADDR_W-1:0] codeLim;
        off = a - FLASH_BASE;
        bootLim = ADDR_W'({boot_section_end, 8'h00}); // RL2
        codeLim = ADDR_W'({codeEnd, 8'h00});
        if (boot_section_end == NO_SECTION_END && codeEnd == NO_SECTION_END) begin
            return SEC_BOOT; // RL5
        end else if (off < bootLim) begin
            return SEC_BOOT; // RL3
        end else if (codeEnd == NO_SECTION_END || off < codeLim) begin
            return SEC_APPLICATION_CODE_SECTION; // RL4
        end
        return SEC_APPLICATION_DATA_SECTION; // RL3
    endfunction

    logic [7:0] bufByte [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] bufMark;
    logic [ADDR_W-1:0] bufPage_reg;
    logic [ADDR_W-1:0] bufPage_next;
    nsp_region_e bufRegion_reg;
    nsp_region_e bufRegion_next;
    logic appLock_reg;
    logic boot_section_lock_reg;
    logic writeErr_reg;
    logic intEn_reg;
    logic [2:0] unlockCnt_reg;
    logic [2:0] unlockCnt_next;
    logic flashBusy_reg;
    logic eeprom_busy_flag_reg;
    logic [CMD_W-1:0] opKind_reg;
    nsp_region_e opRegion_reg;
    logic [ADDR_W-1:0] opPage_reg;
    logic [PAGE_BYTES-1:0] opMask_reg;
    logic [7:0] memRdata_reg;
    logic [31:0] prdata_reg;

    // apb decode
    wire logic apbSetup = psel & ~penable;
    wire logic apbWr = psel & penable & pwrite;
    wire logic hitCtrla = paddr == REG_CTRLA;
    wire logic hitCtrlb = paddr == REG_CTRLB;
    wire logic hitStatus = paddr == REG_STATUS;
    wire logic hitIntctrl = paddr == REG_INTCTRL;
    wire logic hitUnlock = paddr == REG_UNLOCK;
    wire logic hitAny = hitCtrla | hitCtrlb | hitStatus |
                        hitIntctrl | hitUnlock;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hitAny;

    // cpu memory access decode
    wire nsp_region_e memRgn = regionOf(memAddr);
    wire nsp_section_e memSec =
        sectionOf(memAddr, bootSectionEnd, appCodeSectionEnd);
    wire logic busy = flashBusy_reg | eeprom_busy_flag_reg;
    wire logic memArray = memRgn != RGN_NONE;
    wire logic bootReadDeny = boot_section_lock_reg & memRgn == RGN_FLASH &
                              memSec == SEC_BOOT;
    assign memReady = ~(memArray & busy); // RL14
    assign memError = memReq & (~memArray | (~memWrite & bootReadDeny)); // RL11
    assign arrRdAddr = memAddr;
    wire logic storeHit = memReq & memWrite & memArray & ~busy; // RL16
    wire logic loadHit = memReq & ~memWrite & memArray & ~busy &
                         ~bootReadDeny;
    wire logic [PG_W-1:0] byteIdx = memAddr[PG_W-1:0]; // RL16

    // fetch refusal from a locked boot section
    wire nsp_section_e execSec =
        sectionOf(execAddr, bootSectionEnd, appCodeSectionEnd);
    wire logic execInFlash = regionOf(execAddr) == RGN_FLASH;
    assign fetchBlocked = boot_section_lock_reg & execInFlash &
                          execSec == SEC_BOOT; // RL11

    // command decode, only inside the unlock window
    wire logic cmdWr = apbWr & hitCtrla & unlockCnt_reg != 3'h0;
    wire nsp_cmd_e cmdVal = nsp_cmd_e'(pwdata[CMD_W-1:0]);
    wire logic cmdClear = cmdWr & cmdVal == CMD_BUF_CLEAR;
    wire logic cmdErase = cmdVal == CMD_ERASE | cmdVal == CMD_ERASE_WRITE;
    wire logic cmdMem = cmdVal == CMD_WRITE | cmdErase; // RL20
    wire logic bufTouched = |bufMark;

    // write permission by writer and target section
    wire nsp_section_e tgtSec =
        sectionOf(bufPage_reg, bootSectionEnd, appCodeSectionEnd);
    wire logic writerData = ~execInFlash | execSec == SEC_APPLICATION_DATA_SECTION;
    wire logic eeTarget = bufRegion_reg == RGN_EEPROM |
                          bufRegion_reg == RGN_USERROW;
    wire logic flashOk =
        bufRegion_reg == RGN_FLASH & tgtSec != SEC_BOOT & // RL10
        ((tgtSec == SEC_APPLICATION_CODE_SECTION & execSec == SEC_BOOT &
          ~appLock_reg) | // RL9
         (tgtSec == SEC_APPLICATION_DATA_SECTION & ~writerData)); // RL7
    wire logic dbgRow = debugAccess & bufRegion_reg == RGN_USERROW; // RL13
    wire logic allowed = dbgRow | (eeTarget & ~writerData) | // RL8
                         flashOk;
    wire logic cmdStart = cmdWr & cmdMem & ~busy & allowed &
                          (~cmdErase | bufTouched); // RL23
    wire logic cmdDenied = cmdWr & cmdMem & ~busy & ~allowed; // RL25
    wire logic opFinish = busy & opDone;
    wire logic bufClr = opFinish | cmdClear | sleepEnter | wakeUp; // RL18

    // page buffer bytes and their marks
    genvar gi;
    for (gi = 0; gi < PAGE_BYTES; gi++) begin : g_buf
        wire logic hitByte = storeHit & byteIdx == PG_W'(gi);
        always_ff @(posedge clk) begin
            if (!rst_b || bufClr) begin
                bufByte[gi] <= ERASED_BYTE; // RL18
                bufMark[gi] <= 1'b0;
            end else if (hitByte) begin
                bufByte[gi] <= bufByte[gi] & memWdata; // RL17
                bufMark[gi] <= 1'b1; // RL12
            end
        end
        assign opData[gi*8 +: 8] = bufByte[gi];
    end

    // one buffer, retargeted by the latest store
    assign bufPage_next = storeHit ? (memAddr & PAGE_MASK) : bufPage_reg;
    assign bufRegion_next = storeHit ? memRgn : bufRegion_reg; // RL15
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            bufPage_reg <= FLASH_BASE;
            bufRegion_reg <= RGN_NONE;
        end else begin
            bufPage_reg <= bufPage_next;
            bufRegion_reg <= bufRegion_next;
        end
    end

    // unlock window countdown
    assign unlockCnt_next =
        (apbWr & hitUnlock & pwdata[7:0] == UNLOCK_KEY) ? UNLOCK_WINDOW :
        cmdWr ? 3'h0 :
        (unlockCnt_reg != 3'h0) ? unlockCnt_reg - 3'h1 : 3'h0;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            unlockCnt_reg <= 3'h0;
        end else begin
            unlockCnt_reg <= unlockCnt_next;
        end
    end

    // locks set only, cleared by reset alone
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            appLock_reg <= 1'b0;
            boot_section_lock_reg <= 1'b0;
        end else if (apbWr && hitCtrlb) begin
            appLock_reg <= appLock_reg | pwdata[CTRLB_APPLOCK_BIT]; // RL9
            boot_section_lock_reg <= boot_section_lock_reg | pwdata[CTRLB_BOOT_SECTION_LOCK_BIT]; // RL9
        end
    end

    // error flag and ready enable; a new error beats the clear
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            writeErr_reg <= 1'b0;
            intEn_reg <= 1'b0;
        end else begin
            if (cmdDenied) begin
                writeErr_reg <= 1'b1;
            end else if (apbWr && hitStatus && pwdata[STATUS_WERR_BIT]) begin
                writeErr_reg <= 1'b0;
            end
            if (apbWr && hitIntctrl) begin
                intEn_reg <= pwdata[INTCTRL_EEPROM_READY_EVENT_BIT];
            end
        end
    end

    // array operation launch and completion
    always_ff @(posedge clk) begin
        if (!rst_b || opFinish) begin
            flashBusy_reg <= 1'b0;
            eeprom_busy_flag_reg <= 1'b0;
        end else if (cmdStart) begin
            flashBusy_reg <= bufRegion_reg == RGN_FLASH;
            eeprom_busy_flag_reg <= eeTarget;
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            opKind_reg <= CMD_W'(CMD_NONE);
            opRegion_reg <= RGN_NONE;
            opPage_reg <= FLASH_BASE;
            opMask_reg <= '0;
        end else if (cmdStart) begin
            opKind_reg <= pwdata[CMD_W-1:0];
            opRegion_reg <= bufRegion_reg;
            opPage_reg <= bufPage_reg;
            opMask_reg <= eeTarget ? bufMark : '1; // RL1 RL12
        end
    end
    assign opValid = busy;
    assign opKind = opKind_reg;
    assign opRegion = opRegion_reg;
    assign opPageAddr = opPage_reg;
    assign opMask = opMask_reg;
    assign flashBusyFlag = flashBusy_reg;
    assign eepromBusyFlag = eeprom_busy_flag_reg;
    assign cpuHalt = flashBusy_reg; // RL21
    assign eepromReadyEvent = intEn_reg & ~eeprom_busy_flag_reg; // RL24

    // load data, one cycle after the accepted load
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            memRdata_reg <= 8'h00;
        end else if (loadHit) begin
            memRdata_reg <= arrRdData;
        end
    end
    assign memRdata = memRdata_reg;

    // apb read data, captured in the setup cycle
    wire logic [31:0] statusWord = {29'h0, writeErr_reg, eeprom_busy_flag_reg,
                                    flashBusy_reg};
    wire logic [31:0] rdMux =
        hitCtrla ? {29'h0, opKind_reg} :
        hitCtrlb ? {30'h0, boot_section_lock_reg, appLock_reg} :
        hitStatus ? statusWord :
        hitIntctrl ? {31'h0, intEn_reg} : 32'h0;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            prdata_reg <= 32'h0;
        end else if (apbSetup && !pwrite) begin
            prdata_reg <= rdMux;
        end
    end
    assign prdata = prdata_reg;
endmodule

/* hdl/nsp_pkg.sv */
package nsp_pkg;
    // address map of the nonvolatile arrays
    localparam int ADDR_W = 16;
    localparam logic [15:0] USERROW_BASE = 16'h1300;
    localparam logic [15:0] USERROW_BYTES = 16'h0040;
    localparam logic [15:0] EEPROM_BASE = 16'h1400;
    localparam logic [15:0] EEPROM_BYTES = 16'h0100;
    localparam logic [15:0] FLASH_BASE = 16'h4000;
    // section boundaries count in 256-byte blocks; this is log2 of the block size
    localparam int BLOCK_SHIFT = 8;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [7:0] NO_SECTION_END = 8'h00;

    // register offsets (byte addresses)
    localparam logic [7:0] REG_CTRLA = 8'h00;
    localparam logic [7:0] REG_CTRLB = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_INTCTRL = 8'h0C;
    localparam logic [7:0] REG_UNLOCK = 8'h10;

    // field positions
    localparam int CMD_W = 3;
    localparam int CTRLB_APPLOCK_BIT = 0;
    localparam int CTRLB_BOOT_SECTION_LOCK_BIT = 1;
    localparam int STATUS_FLASH_BUSY_FLAG_BIT = 0;
    localparam int STATUS_EEPROM_BUSY_FLAG_BIT = 1;
    localparam int STATUS_WERR_BIT = 2;
    localparam int INTCTRL_EEPROM_READY_EVENT_BIT = 0;

    // unlock key is arbitrary; window counts clock cycles
    localparam logic [7:0] UNLOCK_KEY = 8'hA5;
    localparam logic [2:0] UNLOCK_WINDOW = 3'h4;

    typedef enum logic [1:0] {
        RGN_NONE,
        RGN_FLASH,
        RGN_EEPROM,
        RGN_USERROW
    } nsp_region_e;

    typedef enum logic [1:0] {
        SEC_BOOT,
        SEC_APPLICATION_CODE_SECTION,
        SEC_APPLICATION_DATA_SECTION
    } nsp_section_e;

    // command codes follow declaration order: 0 none .. 4 buffer clear
    typedef enum logic [CMD_W-1:0] {
        CMD_NONE,
        CMD_WRITE,
        CMD_ERASE,
        CMD_ERASE_WRITE,
        CMD_BUF_CLEAR
    } nsp_cmd_e;
endpackage

/* tb/nsp_array_model.sv */
module nsp_array_model
    import nsp_pkg::*;
#(
    parameter int PAGE_BYTES = 64,
    parameter int DELAY = 8
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic opValid,
    input wire logic [CMD_W-1:0] opKind,
    input wire logic [ADDR_W-1:0] opPageAddr,
    input wire logic [PAGE_BYTES*8-1:0] opData,
    input wire logic [PAGE_BYTES-1:0] opMask,
    output logic opDone,
    input wire logic [ADDR_W-1:0] arrRdAddr,
    output logic [7:0] arrRdData
);
    logic [7:0] mem [0:65535];
    int cnt = 0;
    int a;

    // flash starts at zero so a full-page rewrite shows
    initial begin
        for (int i = 0; i < 65536; i++) begin
            mem[i] = (i >= 32'(FLASH_BASE)) ? 8'h00 : 8'hFF;
        end
    end
    assign arrRdData = mem[arrRdAddr];

    // busy for DELAY cycles, then marked bytes only
    always @(posedge clk) begin
        opDone <= 1'h0;
        cnt <= cnt + 1;
        if (!rst_b || !opValid || opDone) begin
            cnt <= 0;
        end else if (cnt == DELAY) begin
            opDone <= 1'h1;
            for (int i = 0; i < PAGE_BYTES; i++) begin
                a = int'(opPageAddr) + i;
                if (opMask[i]) begin
                    case (opKind)
                        CMD_ERASE: mem[a] <= 8'hFF;
                        CMD_WRITE: mem[a] <= mem[a] & opData[i*8 +: 8];
                        default: mem[a] <= opData[i*8 +: 8];
                    endcase
                end
            end
        end
    end
endmodule

/* tb/nsp_page_buffer_ctrl_assertions.sv */
module nsp_page_buffer_ctrl_assertions
    import nsp_pkg::*;
#(
    parameter int PAGE_BYTES = 64,
    parameter int FLASH_BYTES = 8192
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic memReq,
    input wire logic memWrite,
    input wire logic [ADDR_W-1:0] memAddr,
    input wire logic [7:0] memWdata,
    input wire logic memReady,
    input wire logic cpuHalt,
    input wire logic sleepEnter,
    input wire logic wakeUp,
    input wire logic opValid,
    input wire logic [1:0] opRegion,
    input wire logic [PAGE_BYTES*8-1:0] opData,
    input wire logic [PAGE_BYTES-1:0] opMask,
    input wire logic opDone,
    input wire logic eepromBusyFlag,
    input wire logic eepromReadyEvent
);
    localparam int PB = $clog2(PAGE_BYTES);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    // array decode and the buffer byte a store lands on
    wire logic isArr;
    wire logic [7:0] oldByte;
    assign isArr = (memAddr >= USERROW_BASE
        && memAddr < USERROW_BASE + USERROW_BYTES)
        || (memAddr >= EEPROM_BASE && memAddr < EEPROM_BASE + EEPROM_BYTES)
        || (memAddr >= FLASH_BASE && memAddr < FLASH_BASE + FLASH_BYTES);
    assign oldByte = opData[memAddr[PB-1:0]*8 +: 8];

    // steps of a buffer load and of an array operation
    sequence storeTaken;
        memReq && memReady && memWrite && isArr && !sleepEnter && !wakeUp;
    endsequence
    sequence opEnds;
        opValid && opDone;
    endsequence

    stall_busy_a: assert property (
        opValid && memReq && isArr |-> !memReady)
        else $error("array access not stalled while busy");
    op_hold_a: assert property (
        opValid && !opDone |=> opValid)
        else $error("operation dropped before done");
    op_clear_a: assert property (
        opEnds |=> !opValid && (&opData))
        else $error("buffer not all ones after operation");
    sleep_clear_a: assert property (
        sleepEnter || wakeUp |=> &opData)
        else $error("buffer not all ones after sleep or wake");
    and_merge_a: assert property (
        storeTaken |=> opData[$past(memAddr[PB-1:0])*8 +: 8]
        == ($past(oldByte) & $past(memWdata)))
        else $error("buffer byte is not old and new");
    flash_mask_a: assert property (
        opValid && opRegion == 2'(RGN_FLASH) |-> &opMask)
        else $error("flash operation on partial page");
    halt_flash_a: assert property (
        eepromBusyFlag |-> !cpuHalt)
        else $error("cpu halted by eeprom operation");
    ready_event_a: assert property (
        eepromBusyFlag |-> !eepromReadyEvent)
        else $error("ready event while eeprom busy");
endmodule

/* tb/tb_nsp_page_buffer_ctrl.sv */
module tb_nsp_page_buffer_ctrl
    import nsp_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'h0, rst_b = 1'h0, psel = 1'h0, penable = 1'h0;
    logic pwrite = 1'h0, pready, pslverr, lastErr, memError, fetchBlocked;
    logic [7:0] paddr = 8'h00, memWdata = 8'h00, memRdata, arrRdData;
    logic [31:0] pwdata = 32'h0, prdata, lastRd;
    logic memReq = 1'h0, memWrite = 1'h0, memReady, cpuHalt, opValid, opDone;
    logic [15:0] memAddr = 16'h0, execAddr = 16'h4500, arrRdAddr, opPageAddr;
    logic [7:0] bootSectionEnd = 8'h04, appCodeSectionEnd = 8'h08;
    logic sleepEnter = 1'h0, wakeUp = 1'h0, debugAccess = 1'h0;
    logic flashBusyFlag, eepromBusyFlag, eepromReadyEvent;
    logic [2:0] opKind;
    logic [1:0] opRegion;
    logic [511:0] opData;
    logic [63:0] opMask;
    int err_count = 0, compares = 0;

    nsp_page_buffer_ctrl nsp_page_buffer_ctrl_i (.clk, .rst_b, .paddr, .psel,
        .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .memReq,
        .memWrite, .memAddr, .memWdata, .memRdata, .memReady, .memError,
        .execAddr, .fetchBlocked, .cpuHalt, .bootSectionEnd, .appCodeSectionEnd,
        .sleepEnter, .wakeUp, .debugAccess, .arrRdAddr, .arrRdData, .opValid,
        .opKind, .opRegion, .opPageAddr, .opData, .opMask, .opDone,
        .flashBusyFlag, .eepromBusyFlag, .eepromReadyEvent);
    nsp_array_model nsp_array_model_i (.clk, .rst_b, .opValid, .opKind,
        .opPageAddr, .opData, .opMask, .opDone, .arrRdAddr, .arrRdData);

    always #5 clk = ~clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("mismatches %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic tick();
        @(posedge clk);
        #1;
    endtask
    // one apb transfer, held until pready
    task automatic apb(input logic wr, input logic [7:0] a, input int d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'h1 && n < 50);
        if (pready !== 1'h1) begin
            err_count++;
            end_of_test();
        end
        lastRd = prdata;
        lastErr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        #1;
    endtask
    // one cpu load or store, held until memReady
    task automatic mem(input logic wr, input logic [15:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        memReq <= 1'h1;
        memWrite <= wr;
        memAddr <= a;
        memWdata <= d;
        do begin
            @(posedge clk);
            n++;
        end while (memReady !== 1'h1 && n < 200);
        if (memReady !== 1'h1) begin
            err_count++;
            end_of_test();
        end
        memReq <= 1'h0;
        #1;
    endtask
    task automatic cmd(input logic [2:0] c);
        apb(1'h1, REG_UNLOCK, 32'(UNLOCK_KEY));
        apb(1'h1, REG_CTRLA, 32'(c));
        tick();
    endtask

    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1'h1;
        #1;
        apb(1'h0, REG_CTRLB, 0);
        check(lastRd, 0);
        apb(1'h0, 8'h14, 0);
        check(lastErr, 1);
        check(&opData, 1);
        mem(1'h1, 16'h1405, 8'h3C);
        mem(1'h1, 16'h1405, 8'hF0);
        check(opData[47:40], 8'h30);
        check(opData[39:32], 8'hFF);
        apb(1'h1, REG_INTCTRL, 1);
        check(eepromReadyEvent, 1);
        cmd(CMD_WRITE);
        check(cpuHalt, 0);
        @(posedge clk);
        memReq <= 1'h1;
        memWrite <= 1'h0;
        memAddr <= 16'h1405;
        #1;
        check(memReady, 0);
        mem(1'h0, 16'h1405, 8'h00);
        check(memRdata, 8'h30);
        mem(1'h0, 16'h1404, 8'h00);
        check(memRdata, 8'hFF);
        @(posedge clk);
        execAddr <= 16'h4900;
        mem(1'h1, 16'h4810, 8'h00);
        cmd(CMD_WRITE);
        check(opValid, 0);
        apb(1'h0, REG_STATUS, 0);
        check(lastRd[2], 1);
        cmd(CMD_BUF_CLEAR);
        check(&opData, 1);
        @(posedge clk);
        execAddr <= 16'h4000;
        cmd(CMD_ERASE);
        check(opValid, 0);
        mem(1'h1, 16'h4410, 8'h12);
        cmd(CMD_ERASE_WRITE);
        check(cpuHalt, 1);
        mem(1'h0, 16'h4410, 8'h00);
        check(memRdata, 8'h12);
        mem(1'h0, 16'h4411, 8'h00);
        check(memRdata, 8'hFF);
        mem(1'h1, 16'h4010, 8'h00);
        cmd(CMD_WRITE);
        check(opValid, 0);
        apb(1'h1, REG_CTRLB, 1);
        mem(1'h1, 16'h4410, 8'h00);
        cmd(CMD_WRITE);
        check(opValid, 0);
        apb(1'h1, REG_CTRLB, 2);
        @(posedge clk);
        memReq <= 1'h1;
        memWrite <= 1'h0;
        memAddr <= 16'h4010;
        #1;
        check(memError, 1);
        check(fetchBlocked, 1);
        @(posedge clk);
        execAddr <= 16'h4900;
        debugAccess <= 1'h1;
        mem(1'h1, 16'h1300, 8'h5A);
        cmd(CMD_WRITE);
        check(opValid, 1);
        mem(1'h0, 16'h1300, 8'h00);
        check(memRdata, 8'h5A);
        for (int i = 0; i < 2; i++) begin
            mem(1'h1, 16'h1400, 8'h00);
            check(opData[7:0], 8'h00);
            @(posedge clk);
            sleepEnter <= (i == 0);
            wakeUp <= (i == 1);
            @(posedge clk);
            sleepEnter <= 1'h0;
            wakeUp <= 1'h0;
            #1;
            check(&opData, 1);
        end
        end_of_test();
    end
endmodule

bind nsp_page_buffer_ctrl nsp_page_buffer_ctrl_assertions #(
    .PAGE_BYTES(PAGE_BYTES), .FLASH_BYTES(FLASH_BYTES)
) nsp_page_buffer_ctrl_assertions_i (.clk, .rst_b, .memReq, .memWrite,
    .memAddr, .memWdata, .memReady, .cpuHalt, .sleepEnter, .wakeUp, .opValid,
    .opRegion, .opData, .opMask, .opDone, .eepromBusyFlag, .eepromReadyEvent);
